/* File: hw/hot_swap_pkg.sv */
// Operation
// - mode is sampled once when a supply first passes lockout, then held.
// - mode high selects tracking; all three channels switch on and off together.
// - no channel turns on before a supply sat above lockout for 37.5ms.
// - tracking runs only with all supplies ready, all on-inputs high, no fault.
// - tracking: cycling any on-input after a latched fault restarts all channels.
// - mode open selects sequencing; own on-input, all supplies ready, no fault.
// - sequencing: cycling any on-input clears; each restarts per its own on-input.
// - mode grounded: each channel follows its own supply-ready and on-input.
// - independent: a fault stops only its channel; own on-input cycle restarts it.
// - startup period 0.4ms to 51ms, 9ms when the setting is open.
// - startup timer starts only with conditions met, no latch, no retry wait.
// - during startup slow trip ignored, gate current limited, fast trip regulates.
// - after startup status asserts at once if fault free; normal operation begins.
// - normal slow trip gives fault, status off, 3mA gate discharge.
// - normal fast trip gives fault within 200ns, status off, 50mA discharge.
// - slow threshold 25mV to 100mV; fast and startup thresholds are twice it.
// - all supplies below lockout past the glitch time restart delay and startup.
// - latch select open: overcurrent keeps gates off until cleared by on-input.
// - latch select grounded: gates off, automatic restart after 64 startup periods.
// - status deasserts while on-input is low or the channel is off by fault.
// - polarity select decides whether status asserts high or low.
package hot_swap_pkg;
	localparam int CHANNELS = 3;
	localparam int CLOCK_PERIOD_NS = 5;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLOCK_PERIOD_NS;
	localparam real LOCKOUT_DELAY_MS = 37.5;
	localparam int LOCKOUT_DELAY_TICKS = int'(LOCKOUT_DELAY_MS * 1.0e6 / TICK_NS);
	localparam real STARTUP_MIN_MS = 0.4;
	localparam real STARTUP_MAX_MS = 51.0;
	localparam real STARTUP_DEFAULT_MS = 9.0;
	localparam logic [15:0] STARTUP_MIN_TICKS = 16'(int'(STARTUP_MIN_MS * 1.0e6 / TICK_NS));
	localparam logic [15:0] STARTUP_MAX_TICKS = 16'(int'(STARTUP_MAX_MS * 1.0e6 / TICK_NS));
	localparam logic [15:0] STARTUP_DEFAULT_TICKS = 16'(int'(STARTUP_DEFAULT_MS * 1.0e6 / TICK_NS));
	localparam int RETRY_SHIFT = 6;
	localparam int ON_CLEAR_US = 100;
	localparam logic [6:0] ON_CLEAR_TICKS = 7'(ON_CLEAR_US * 1000 / TICK_NS);
	localparam int GLITCH_FILTER_US = 16;
	localparam logic [7:0] GLITCH_TICKS = 8'(GLITCH_FILTER_US * 1000 / TICK_NS);
	localparam int FAST_FAULT_NS = 200;
	localparam int FAST_FAULT_CYCLES = FAST_FAULT_NS / CLOCK_PERIOD_NS;
	localparam logic [6:0] SLOW_TH_MIN_MV = 7'h19;
	localparam logic [6:0] SLOW_TH_MAX_MV = 7'h64;

	typedef enum logic [1:0] {
		MODE_INDEPENDENT = 2'h0,
		MODE_SEQUENCING  = 2'h1,
		MODE_TRACKING    = 2'h2
	} mode_t;

	typedef enum logic [2:0] {
		CH_OFF     = 3'h0,
		CH_STARTUP = 3'h1,
		CH_NORMAL  = 3'h3,
		CH_FAULT   = 3'h2,
		CH_RETRY   = 3'h6
	} ch_state_t;
endpackage

/* File: hw/chan_if.sv */
`timescale 1ns/1ps
interface chan_if;
	import hot_swap_pkg::*;
	logic        ce;
	logic        tick;
	logic        run;
	logic        clear;
	logic        latched;
	logic        on_above;
	logic        slow_trip;
	logic        fast_trip;
	logic [15:0] startup_ticks;
	ch_state_t   state;
	logic        timer_done;
	logic        on_low_long;
	logic        gate_on;
	logic        limit;
	logic        regulate;
	logic        slow_dis;
	logic        fast_dis;
	logic        faulty;
	logic        status;
	modport ctrl (output ce, tick, run, clear, latched, on_above, slow_trip, fast_trip, startup_ticks,
		input state, timer_done, on_low_long, gate_on, limit, regulate, slow_dis, fast_dis, faulty, status);
	modport chan (input ce, tick, run, clear, latched, on_above, slow_trip, fast_trip, startup_ticks,
		output state, timer_done, on_low_long, gate_on, limit, regulate, slow_dis, fast_dis, faulty, status);
endinterface

/* File: hw/supply_supervisor.sv */
`timescale 1ns/1ps
module supply_supervisor
	import hot_swap_pkg::*;
#(
	parameter int TICK_LEN     = TICK_CYCLES,
	parameter int LOCKOUT_LEN  = LOCKOUT_DELAY_TICKS
) (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst,
	input  wire logic i_ce,
	// supply state
	input  wire logic i_any_lockout,
	output logic      o_tick,
	output logic      o_ready
);
	typedef struct packed {
		logic [15:0] tick_cnt;
		logic        tick;
		logic [7:0]  low_cnt;
		logic        down;
		logic [23:0] dly;
		logic        ready;
	} sup_t;

	sup_t s;
	sup_t next_s;

	// time base, glitch filter and lockout delay
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.tick_cnt == 16'(TICK_LEN - 1)) begin
			next_s.tick_cnt = 16'h0000;
			next_s.tick = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 16'h0001;
		end
		if (i_any_lockout) begin
			next_s.low_cnt = 8'h00;
			if (s.down) begin
				next_s.down = 1'b0;
				next_s.dly = 24'h00_0000;
			end else if (s.tick && !s.ready) begin
				if (s.dly == 24'(LOCKOUT_LEN - 1))
					next_s.ready = 1'b1;
				else
					next_s.dly = s.dly + 24'h00_0001;
			end
		end else if (s.tick && !s.down) begin
			if (s.low_cnt == GLITCH_TICKS - 8'h01) begin
				next_s.down = 1'b1;
				next_s.ready = 1'b0;
			end else begin
				next_s.low_cnt = s.low_cnt + 8'h01;
			end
		end
	end

	// state register
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s <= '{tick_cnt: 16'h0000, tick: 1'b0, low_cnt: 8'h00, down: 1'b1,
				dly: 24'h00_0000, ready: 1'b0};
		end else if (i_ce) begin
			s <= next_s;
		end
	end

	assign o_tick = s.tick;
	assign o_ready = s.ready;
endmodule

/* File: hw/channel_ctrl.sv */
`timescale 1ns/1ps
module channel_ctrl
	import hot_swap_pkg::*;
(
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst,
	// control side
	chan_if.chan      ch
);
	typedef struct packed {
		ch_state_t   state;
		logic [21:0] cnt;
		logic [6:0]  low_cnt;
		logic        fast_kind;
	} chs_t;

	chs_t s;
	chs_t next_s;

	// channel sequence
	always_comb begin
		next_s = s;
		if (ch.on_above)
			next_s.low_cnt = 7'h00;
		else if (ch.tick && s.low_cnt != ON_CLEAR_TICKS)
			next_s.low_cnt = s.low_cnt + 7'h01;
		if (ch.tick && s.cnt != 22'h00_0000)
			next_s.cnt = s.cnt - 22'h00_0001;
		case (s.state)
			CH_OFF: begin
				if (ch.run) begin
					next_s.state = CH_STARTUP;
					next_s.cnt = {6'h00, ch.startup_ticks};
				end
			end
			CH_STARTUP: begin // slow trip not looked at here
				if (!ch.run)
					next_s.state = CH_OFF;
				else if (s.cnt == 22'h00_0000)
					next_s.state = CH_NORMAL;
			end
			CH_NORMAL: begin
				if (ch.fast_trip || ch.slow_trip) begin
					next_s.fast_kind = ch.fast_trip;
					next_s.state = ch.latched ? CH_FAULT : CH_RETRY;
					next_s.cnt = {ch.startup_ticks, 6'h00};
				end else if (!ch.run) begin
					next_s.state = CH_OFF;
				end
			end
			CH_FAULT: begin
				if (ch.clear)
					next_s.state = CH_OFF;
			end
			CH_RETRY: begin
				if (s.cnt == 22'h00_0000)
					next_s.state = CH_OFF;
			end
			default: next_s.state = CH_OFF;
		endcase
	end

	// state register
	always_ff @(posedge i_clock) begin
		if (i_rst)
			s <= '{state: CH_OFF, cnt: 22'h00_0000, low_cnt: 7'h00, fast_kind: 1'b0};
		else if (ch.ce)
			s <= next_s;
	end

	// gate and status drive from the state
	assign ch.state = s.state;
	assign ch.timer_done = (s.cnt == 22'h00_0000);
	// clear is one pulse as a low on-input reaches the clear time; a held-low input cannot clear later faults
	assign ch.on_low_long = ch.tick && !ch.on_above && (s.low_cnt == ON_CLEAR_TICKS - 7'h01);
	assign ch.gate_on = (s.state == CH_STARTUP) || (s.state == CH_NORMAL);
	assign ch.limit = (s.state == CH_STARTUP);
	assign ch.regulate = (s.state == CH_STARTUP) && ch.fast_trip;
	assign ch.faulty = (s.state == CH_FAULT) || (s.state == CH_RETRY);
	assign ch.slow_dis = ch.faulty && !s.fast_kind;
	assign ch.fast_dis = ch.faulty && s.fast_kind;
	assign ch.status = (s.state == CH_NORMAL) && ch.on_above;
endmodule

/* File: hw/triple_hot_swap_sequencer.sv */
`timescale 1ns/1ps
module triple_hot_swap_sequencer
	import hot_swap_pkg::*;
#(
	parameter int TICK_LEN    = TICK_CYCLES,
	parameter int LOCKOUT_LEN = LOCKOUT_DELAY_TICKS
) (
	// clock, reset, enable
	input  wire logic        I_CLOCK,
	input  wire logic        I_RST,
	input  wire logic        I_CLK_EN,
	// straps
	input  wire logic [1:0]  I_MODE,
	input  wire logic        I_LATCH_OPEN,
	input  wire logic        I_POL_OPEN,
	input  wire logic        I_STARTUP_TIME_OPEN,
	input  wire logic [15:0] I_STARTUP_TIME_SETTING,
	input  wire logic [6:0]  I_SLOW_THRESHOLD_MV,
	// comparator results per channel
	input  wire logic [2:0]  I_LOCKOUT_OK,
	input  wire logic [2:0]  I_POWER_READY,
	input  wire logic [2:0]  I_ON_ABOVE,
	input  wire logic [2:0]  I_SLOW_TRIP,
	input  wire logic [2:0]  I_FAST_TRIP,
	// gate drive per channel
	output logic [2:0]       O_GATE_ON,
	output logic [2:0]       O_GATE_LIMIT,
	output logic [2:0]       O_GATE_REGULATE,
	output logic [2:0]       O_SLOW_DISCHARGE,
	output logic [2:0]       O_FAST_DISCHARGE,
	// status pins, open drain
	output logic [2:0]       O_STATUS_OUT,
	output logic [2:0]       O_STATUS_OE,
	// thresholds and observation
	output logic [6:0]       O_SLOW_THRESHOLD_MV,
	output logic [7:0]       O_FAST_THRESHOLD_MV,
	output logic [2:0]       O_FAULT,
	output logic [1:0]       O_MODE,
	output logic             O_LOCKOUT_READY
);
	typedef struct packed {
		mode_t      mode;
		logic       mode_taken;
		logic       status_polarity_select;
		logic [2:0] gate;
		logic [2:0] limit;
		logic [2:0] regulate;
		logic [2:0] slow_dis;
		logic [2:0] fast_dis;
		logic [2:0] status;
		logic [2:0] fault;
		logic [6:0] slow_th;
	} top_t;

	top_t s;
	top_t next_s;

	logic        tick;
	logic        sup_ready;
	logic        all_ready;
	logic        all_on;
	logic        any_fault;
	logic        any_low_long;
	logic [15:0] startup_ticks;
	logic [2:0]  ch_gate;
	logic [2:0]  ch_limit;
	logic [2:0]  ch_reg;
	logic [2:0]  ch_slow;
	logic [2:0]  ch_fast;
	logic [2:0]  ch_status;
	logic [2:0]  ch_faulty;
	logic [2:0]  ch_low_long;

	chan_if cif[CHANNELS] ();

	// time base and lockout supervision
	supply_supervisor #(
		.TICK_LEN    (TICK_LEN),
		.LOCKOUT_LEN (LOCKOUT_LEN)
	) u_supervisor (
		.i_clock       (I_CLOCK),
		.i_rst         (I_RST),
		.i_ce          (I_CLK_EN),
		.i_any_lockout (|I_LOCKOUT_OK),
		.o_tick        (tick),
		.o_ready       (sup_ready)
	);

	// startup period from the timing strap, clamped to its range
	always_comb begin
		if (I_STARTUP_TIME_OPEN)
			startup_ticks = STARTUP_DEFAULT_TICKS;
		else if (I_STARTUP_TIME_SETTING < STARTUP_MIN_TICKS)
			startup_ticks = STARTUP_MIN_TICKS;
		else if (I_STARTUP_TIME_SETTING > STARTUP_MAX_TICKS)
			startup_ticks = STARTUP_MAX_TICKS;
		else
			startup_ticks = I_STARTUP_TIME_SETTING;
	end

	// group conditions
	assign all_ready = &I_POWER_READY;
	assign all_on = &I_ON_ABOVE;
	assign any_fault = |ch_faulty;
	assign any_low_long = |ch_low_long;

	// one controller per channel
	generate
		for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
			channel_ctrl u_ch (
				.i_clock (I_CLOCK),
				.i_rst   (I_RST),
				.ch      (cif[g])
			);
			assign cif[g].ce = I_CLK_EN;
			assign cif[g].tick = tick;
			assign cif[g].latched = I_LATCH_OPEN;
			assign cif[g].on_above = I_ON_ABOVE[g];
			assign cif[g].slow_trip = I_SLOW_TRIP[g];
			assign cif[g].fast_trip = I_FAST_TRIP[g];
			assign cif[g].startup_ticks = startup_ticks;
			// turn-on condition for the sampled mode
			always_comb begin
				if (!s.mode_taken || !sup_ready)
					cif[g].run = 1'b0;
				else if (s.mode == MODE_INDEPENDENT)
					cif[g].run = I_POWER_READY[g] && I_ON_ABOVE[g];
				else if (s.mode == MODE_TRACKING)
					cif[g].run = all_ready && all_on && !any_fault;
				else
					cif[g].run = all_ready && I_ON_ABOVE[g] && !any_fault;
			end
			// fault clear: own on-input alone, or any on-input in group modes
			assign cif[g].clear = (s.mode == MODE_INDEPENDENT) ? cif[g].on_low_long
				: any_low_long;
			assign ch_gate[g] = cif[g].gate_on;
			assign ch_limit[g] = cif[g].limit;
			assign ch_reg[g] = cif[g].regulate;
			assign ch_slow[g] = cif[g].slow_dis;
			assign ch_fast[g] = cif[g].fast_dis;
			assign ch_status[g] = cif[g].status;
			assign ch_faulty[g] = cif[g].faulty;
			assign ch_low_long[g] = cif[g].on_low_long;

			// startup ignores the slow comparator
			slow_ignored_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].state == CH_STARTUP && cif[g].run |=> cif[g].state != CH_FAULT && cif[g].state != CH_RETRY)
				else $error("fault raised during startup");
			// fast trip in normal operation
			fast_fault_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].state == CH_NORMAL && I_FAST_TRIP[g] |=> cif[g].fast_dis ##1 O_FAST_DISCHARGE[g])
				else $error("fast trip did not raise a fault in time");
			// latched fault holds until cleared
			latch_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].state == CH_FAULT && !cif[g].clear |=> cif[g].state == CH_FAULT)
				else $error("latched fault left without clear");
			// retry waits out its delay
			retry_wait_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].state == CH_RETRY && !cif[g].timer_done |=> cif[g].state == CH_RETRY && !cif[g].gate_on)
				else $error("retry delay cut short");
			// status drops with the on-input
			status_on_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				!I_ON_ABOVE[g] |=> !s.status[g])
				else $error("status asserted with on-input low");
			// status follows the end of startup
			status_end_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].state == CH_STARTUP && cif[g].timer_done && cif[g].run && I_ON_ABOVE[g]
				##1 !I_FAST_TRIP[g] && !I_SLOW_TRIP[g] && I_ON_ABOVE[g] |=> s.status[g])
				else $error("status late after startup");
			// a cleared latch restarts the channel
			clear_restart_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].state == CH_FAULT && cif[g].clear |=> cif[g].state == CH_OFF)
				else $error("clear did not release the latch");
			// a fault always drops status
			status_fault_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].faulty |=> !s.status[g])
				else $error("status asserted during fault");
			// startup drives the limited gate current
			limit_startup_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].state == CH_STARTUP |=> s.limit[g])
				else $error("gate current not limited in startup");
			// no startup without the turn-on conditions
			startup_wait_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].state == CH_OFF && !cif[g].run |=> cif[g].state == CH_OFF)
				else $error("startup began without turn-on conditions");
			// tracking needs every on-input
			track_off_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				s.mode == MODE_TRACKING && !all_on |=> !cif[g].gate_on)
				else $error("tracking channel on with an on-input low");
			// sequencing needs the channel's own on-input
			seq_own_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				s.mode == MODE_SEQUENCING && !I_ON_ABOVE[g] |=> !cif[g].gate_on)
				else $error("sequenced channel on with its on-input low");
			// independent channel needs its own supply
			indep_ready_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				s.mode == MODE_INDEPENDENT && !I_POWER_READY[g] |=> !cif[g].gate_on)
				else $error("independent channel on without its supply");
			// independent channel ignores the others
			indep_isolate_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				s.mode == MODE_INDEPENDENT && cif[g].state == CH_NORMAL && cif[g].run && !I_FAST_TRIP[g]
				&& !I_SLOW_TRIP[g] |=> cif[g].state == CH_NORMAL)
				else $error("independent channel stopped by another channel");
			// retry ends in a fresh start
			retry_end_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
				cif[g].state == CH_RETRY && cif[g].timer_done |=> cif[g].state == CH_OFF)
				else $error("retry did not end after its delay");
		end
	endgenerate

	// output and strap registers
	always_comb begin
		next_s = s;
		if (!s.mode_taken && |I_LOCKOUT_OK) begin
			next_s.mode_taken = 1'b1;
			next_s.mode = (I_MODE == 2'h3) ? MODE_TRACKING : mode_t'(I_MODE);
		end
		next_s.status_polarity_select = I_POL_OPEN;
		next_s.gate = ch_gate;
		next_s.limit = ch_limit;
		next_s.regulate = ch_reg;
		next_s.slow_dis = ch_slow;
		next_s.fast_dis = ch_fast;
		next_s.status = ch_status;
		next_s.fault = ch_faulty;
		// slow threshold kept in range
		if (I_SLOW_THRESHOLD_MV < SLOW_TH_MIN_MV)
			next_s.slow_th = SLOW_TH_MIN_MV;
		else if (I_SLOW_THRESHOLD_MV > SLOW_TH_MAX_MV)
			next_s.slow_th = SLOW_TH_MAX_MV;
		else
			next_s.slow_th = I_SLOW_THRESHOLD_MV;
	end

	// state register
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			s <= '{mode: MODE_TRACKING, mode_taken: 1'b0, status_polarity_select: 1'b1, gate: 3'h0, limit: 3'h0,
				regulate: 3'h0, slow_dis: 3'h0, fast_dis: 3'h0, status: 3'h0, fault: 3'h0,
				slow_th: SLOW_TH_MIN_MV};
		end else if (I_CLK_EN) begin
			s <= next_s;
		end
	end

	// pin drive
	assign O_GATE_ON = s.gate;
	assign O_GATE_LIMIT = s.limit;
	assign O_GATE_REGULATE = s.regulate;
	assign O_SLOW_DISCHARGE = s.slow_dis;
	assign O_FAST_DISCHARGE = s.fast_dis;
	assign O_FAULT = s.fault;
	assign O_MODE = s.mode;
	assign O_LOCKOUT_READY = sup_ready;
	assign O_SLOW_THRESHOLD_MV = s.slow_th;
	assign O_FAST_THRESHOLD_MV = {s.slow_th, 1'b0};
	assign O_STATUS_OUT = 3'h0; // open drain only pulls low
	// open: released when asserted; low polarity: pulled when asserted
	assign O_STATUS_OE = s.status ^ {3{s.status_polarity_select}};

	// mode held once sampled
	mode_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		s.mode_taken |=> $stable(s.mode) && s.mode_taken)
		else $error("mode changed after sampling");

	// no gate before the lockout delay
	lockout_first_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		$rose(|ch_gate) |-> $past(sup_ready) && s.mode_taken)
		else $error("gate on before lockout delay");

	// tracking channels move together
	track_together_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
		s.mode == MODE_TRACKING && ch_gate != 3'h0 && ch_gate != 3'h7 |=> ch_gate == 3'h0)
		else $error("tracking channels split");

	// a group fault stops every channel
	group_stop_a: assert property (@(posedge I_CLOCK) disable iff (I_RST || !I_CLK_EN)
		s.mode != MODE_INDEPENDENT && any_fault |=> ch_gate == 3'h0)
		else $error("channel left on during group fault");

	// readiness only drops with no supply above lockout
	glitch_restart_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		$fell(sup_ready) |-> !$past(|I_LOCKOUT_OK))
		else $error("lockout ready lost with a supply present");

	// readiness only grows from a supply above lockout
	ready_supply_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		$rose(sup_ready) |-> $past(|I_LOCKOUT_OK))
		else $error("lockout ready without a supply");

	// a faulted channel never charges its gate
	gate_fault_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(s.gate & s.fault) == 3'h0)
		else $error("gate driven during fault");

	// slow threshold stays in its range
	slow_range_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		s.slow_th >= SLOW_TH_MIN_MV && s.slow_th <= SLOW_TH_MAX_MV)
		else $error("slow threshold out of range");

	// main scenarios
	track_on_c: cover property (@(posedge I_CLOCK) disable iff (I_RST)
		s.mode == MODE_TRACKING && s.status == 3'h7);
	retry_c: cover property (@(posedge I_CLOCK) disable iff (I_RST)
		$fell(s.fault[1]) && !I_LATCH_OPEN);
	latch_clear_c: cover property (@(posedge I_CLOCK) disable iff (I_RST)
		$fell(s.fault[0]) && I_LATCH_OPEN);
	indep_fault_c: cover property (@(posedge I_CLOCK) disable iff (I_RST)
		s.mode == MODE_INDEPENDENT && s.fault == 3'h4 && s.gate == 3'h3);
endmodule

/* File: sim/rail_model.sv */
`timescale 1ns/1ps
module rail_model (
	// clock
	input  wire logic       i_clock,
	// rail and load conditions set by the bench
	input  wire logic [2:0] i_rail_up,
	input  wire logic [2:0] i_short,
	input  wire logic [2:0] i_overload,
	// gate drive from the controller
	input  wire logic [2:0] i_gate_on,
	// comparator results
	output logic [2:0]      o_lockout_ok,
	output logic [2:0]      o_power_ready,
	output logic [2:0]      o_slow_trip,
	output logic [2:0]      o_fast_trip
);
	// comparators settle one clock later; current flows only through a conducting gate
	always @(posedge i_clock) begin
		o_lockout_ok  <= i_rail_up;
		o_power_ready <= i_rail_up;
		o_slow_trip   <= i_overload & i_gate_on;
		o_fast_trip   <= i_short & i_gate_on;
	end
endmodule

/* File: sim/tb_triple_hot_swap_sequencer.sv */
`timescale 1ns/1ps
module tb_triple_hot_swap_sequencer;
	import hot_swap_pkg::*;
	localparam int RETRY_LEN = 400 * 64;
	logic        clk, rst, ce, lat_open, pol_open, tim_open;
	logic [1:0]  mode_in;
	logic [15:0] tim_set;
	logic [6:0]  slow_set;
	logic [2:0]  rails, on_above, short, overload;
	logic [2:0]  lock_ok, pwr_ok, slow_trip, fast_trip;
	logic [2:0]  gate_on, limit, regul, slow_dis, fast_dis, stat_out, stat_oe, fault;
	logic [6:0]  slow_th;
	logic [7:0]  fast_th;
	logic [1:0]  mode_out;
	logic        ready;
	int          fail_count, checks, n;

	rail_model rails_i (.i_clock(clk), .i_rail_up(rails), .i_short(short), .i_overload(overload),
		.i_gate_on(gate_on), .o_lockout_ok(lock_ok), .o_power_ready(pwr_ok),
		.o_slow_trip(slow_trip), .o_fast_trip(fast_trip));

	triple_hot_swap_sequencer #(.TICK_LEN(1), .LOCKOUT_LEN(20)) dut (
		.I_CLOCK(clk), .I_RST(rst), .I_CLK_EN(ce), .I_MODE(mode_in), .I_LATCH_OPEN(lat_open),
		.I_POL_OPEN(pol_open), .I_STARTUP_TIME_OPEN(tim_open), .I_STARTUP_TIME_SETTING(tim_set),
		.I_SLOW_THRESHOLD_MV(slow_set), .I_LOCKOUT_OK(lock_ok), .I_POWER_READY(pwr_ok),
		.I_ON_ABOVE(on_above), .I_SLOW_TRIP(slow_trip), .I_FAST_TRIP(fast_trip),
		.O_GATE_ON(gate_on), .O_GATE_LIMIT(limit), .O_GATE_REGULATE(regul),
		.O_SLOW_DISCHARGE(slow_dis), .O_FAST_DISCHARGE(fast_dis), .O_STATUS_OUT(stat_out),
		.O_STATUS_OE(stat_oe), .O_SLOW_THRESHOLD_MV(slow_th), .O_FAST_THRESHOLD_MV(fast_th),
		.O_FAULT(fault), .O_MODE(mode_out), .O_LOCKOUT_READY(ready));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// verdict and end of run
	task automatic close_out();
		$display("mismatches %0d of %0d comparisons", fail_count, checks);
		if (fail_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// value comparison
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// selects one output group for waiting
	function automatic logic [2:0] pick(input int sel);
		case (sel)
			0: pick = gate_on;
			1: pick = stat_oe;
			2: pick = limit;
			3: pick = {2'h0, ready};
			default: pick = fast_dis;
		endcase
	endfunction

	// bounded wait for an output group to reach a value
	task automatic wait_out(input int sel, input logic [2:0] exp, input int bound, output int cnt);
		for (cnt = 0; cnt < bound; cnt++) begin
			@(negedge clk);
			if (pick(sel) === exp) break;
		end
		checks++;
		if (cnt >= bound) begin
			fail_count++;
			$display("BAD %0t wait on group %0d for %h ran out", $time, sel, exp);
			close_out();
		end
	endtask

	// reset with a strap setting, then raise all rails
	task automatic start_up(input logic [1:0] mode, input logic [2:0] on);
		@(posedge clk);
		rst <= 1'b1;
		mode_in <= mode;
		on_above <= on;
		rails <= 3'h0;
		short <= 3'h0;
		overload <= 3'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(gate_on, 3'h0, "gates after reset");
		chk(mode_out, 2'h2, "mode after reset");
		chk(ready, 1'b0, "ready after reset");
		@(posedge clk);
		rails <= 3'h7;
	endtask

	// tracking: lockout, startup, fast trip, latched clear
	task automatic s_track();
		start_up(2'h2, 3'h7);
		repeat (10) @(negedge clk);
		chk(gate_on, 3'h0, "gate before lockout");
		wait_out(3, 3'h1, 40, n);
		wait_out(0, 3'h7, 20, n);
		chk(limit, 3'h7, "limit in startup");
		@(posedge clk);
		overload <= 3'h7;
		short <= 3'h1;
		repeat (6) @(negedge clk);
		chk(regul[0], 1'b1, "regulate in startup");
		chk(fault, 3'h0, "no fault in startup");
		@(posedge clk);
		overload <= 3'h0;
		short <= 3'h0;
		wait_out(2, 3'h0, 450, n);
		wait_out(1, 3'h0, 5, n);
		chk(slow_th, 7'h32, "slow level");
		chk(fast_th, 8'h64, "fast level");
		chk(stat_out, 3'h0, "status drive level");
		@(posedge clk);
		short <= 3'h1;
		wait_out(4, 3'h1, 40, n);
		wait_out(0, 3'h0, 5, n);
		chk(stat_oe, 3'h7, "status off on fault");
		chk(fault[0], 1'b1, "fault flag");
		@(posedge clk);
		short <= 3'h0;
		repeat (200) @(negedge clk);
		chk(gate_on, 3'h0, "latched stays off");
		@(posedge clk);
		on_above <= 3'h5;
		repeat (110) @(posedge clk);
		on_above <= 3'h7;
		wait_out(0, 3'h7, 40, n);
	endtask

	// independent: per channel control, slow trip, low polarity, mode held
	task automatic s_indep();
		@(posedge clk);
		pol_open <= 1'b0;
		slow_set <= 7'h0a;
		start_up(2'h0, 3'h7);
		wait_out(0, 3'h7, 60, n);
		wait_out(1, 3'h7, 500, n);
		chk(slow_th, 7'h19, "slow clamp");
		@(posedge clk);
		mode_in <= 2'h2;
		overload <= 3'h4;
		wait_out(0, 3'h3, 10, n);
		chk(slow_dis, 3'h4, "slow discharge");
		chk(stat_oe, 3'h3, "status of tripped channel");
		chk(mode_out, 2'h0, "mode held");
		@(posedge clk);
		rails <= 3'h5;
		overload <= 3'h0;
		wait_out(0, 3'h1, 10, n);
	endtask

	// sequencing: own on-input, default startup, latched fault cleared by cycling the on-input
	task automatic s_seq();
		@(posedge clk);
		pol_open <= 1'b1;
		tim_open <= 1'b1;
		start_up(2'h1, 3'h1);
		wait_out(0, 3'h1, 60, n);
		wait_out(2, 3'h0, 9100, n);
		chk(n >= 8990 && n <= 9010, 1'b1, "default startup length");
		@(posedge clk);
		short <= 3'h1;
		wait_out(0, 3'h0, 10, n);
		@(posedge clk);
		short <= 3'h0;
		repeat (150) @(negedge clk);
		chk(gate_on, 3'h0, "latched until cycled");
		@(posedge clk);
		on_above <= 3'h0;
		repeat (110) @(posedge clk);
		on_above <= 3'h1;
		wait_out(0, 3'h1, 200, n);
		chk(gate_on, 3'h1, "only own channel back");
	endtask

	// autoretry delay, then supply glitch handling
	task automatic s_retry();
		@(posedge clk);
		tim_open <= 1'b0;
		lat_open <= 1'b0;
		start_up(2'h2, 3'h7);
		wait_out(1, 3'h0, 600, n);
		@(posedge clk);
		short <= 3'h2;
		wait_out(0, 3'h0, 10, n);
		@(posedge clk);
		short <= 3'h0;
		wait_out(0, 3'h7, RETRY_LEN + 1000, n);
		chk(n >= RETRY_LEN, 1'b1, "retry delay length");
		@(posedge clk);
		rails <= 3'h0;
		repeat (8) @(posedge clk);
		rails <= 3'h7;
		repeat (4) @(negedge clk);
		chk(ready, 1'b1, "short dip filtered");
		@(posedge clk);
		rails <= 3'h0;
		wait_out(3, 3'h0, 40, n);
		wait_out(0, 3'h0, 5, n);
		@(posedge clk);
		rails <= 3'h7;
		wait_out(3, 3'h1, 40, n);
		chk(n >= 20, 1'b1, "lockout delay restarted");
		wait_out(0, 3'h7, 100, n);
		@(posedge clk);
		ce <= 1'b0;
		repeat (500) @(negedge clk);
		chk(limit, 3'h7, "startup frozen");
		@(posedge clk);
		ce <= 1'b1;
		wait_out(2, 3'h0, 450, n);
	endtask

	// main sequence
	initial begin
		fail_count = 0;
		checks = 0;
		rst = 1'b1;
		ce = 1'b1;
		lat_open = 1'b1;
		pol_open = 1'b1;
		tim_open = 1'b0;
		mode_in = 2'h2;
		tim_set = 16'h0190;
		slow_set = 7'h32;
		rails = 3'h0;
		on_above = 3'h0;
		short = 3'h0;
		overload = 3'h0;
		s_track();
		s_indep();
		s_seq();
		s_retry();
		close_out();
	end
endmodule
